// ---- rtl/tbl_boot.sv ----
// Purpose: Tile reset, boot source choice, image loader and security gates.
// Assumes: Flash delivers bytes on valid alone, flash_ready held low; RAM written word-wise.
// Notes:   OTP row 0 holds the security word; image follows at row 1.
`timescale 1ns/1ps
module tbl_boot #(
    parameter int BOOT_DLY = tbl_pkg::TBL_BOOT_DLY_CYC
) (
    input  wire logic        pclk,         // Clock
    input  wire logic        presetn,      // Async reset pin, low
    input  wire logic        psel,         // APB select
    input  wire logic        penable,      // APB enable
    input  wire logic        pwrite,       // APB direction
    input  wire logic [7:0]  paddr,        // APB address
    input  wire logic [31:0] pwdata,       // APB write data
    output logic      [31:0] prdata,       // APB read data
    output logic             pready,       // APB ready
    output logic             pslverr,      // APB error
    input  wire logic        flash_valid,  // Flash byte valid
    input  wire logic [7:0]  flash_data,   // Flash byte
    output logic             flash_ready,  // Held low, not used
    output logic             flash_req,    // Flash read active
    output logic             ram_we,       // RAM write strobe
    output logic      [15:0] ram_addr,     // RAM word address
    output logic      [31:0] ram_wdata,    // RAM write word
    output logic             core_run,     // Processor released
    output logic      [31:0] core_pc,      // Start address
    output logic             gpio_pulldown,// Pin pull-downs on
    output logic             debug_en,     // Debug port allowed
    output logic             link_en,      // Switch access allowed
    output logic             dbg_otp_en,   // Debug OTP access allowed
    output logic             otp_redundant // Redundant rows on
);
    import tbl_pkg::*;

    typedef enum logic [8:0] {
        ST_DELAY  = 9'b000000001,
        ST_SECRD  = 9'b000000010,
        ST_SECLD  = 9'b000000100,
        ST_LEN    = 9'b000001000,
        ST_PROG   = 9'b000010000,
        ST_CHECK  = 9'b000100000,
        ST_VERIFY = 9'b001000000,
        ST_RUN    = 9'b010000000,
        ST_FAIL   = 9'b100000000
    } tbl_state_e;

    // ****************************************
    // Declarations
    // ****************************************
    tbl_state_e  state;
    logic [15:0] dly;
    logic [31:0] sec;
    logic [31:0] shreg;
    logic [1:0]  bcnt;
    logic [31:0] words;
    logic [31:0] wcnt;
    logic        from_otp;
    logic [15:0] otp_row;
    logic [31:0] otp_rdata;
    logic        otp_wait;
    logic [31:0] crc;
    logic        crc_init;
    logic        crc_step;
    logic        byte_ok;
    logic [7:0]  byte_in;
    logic [31:0] word_in;
    logic        crc_err;
    logic        bypass;
    logic [15:0] prog_addr;
    logic [31:0] prog_data;
    logic        prog_wr;
    logic        prog_rej;
    logic        apb_wr;
    logic        apb_rd;
    logic        in_image;

    assign in_image = (state == ST_LEN) || (state == ST_PROG) || (state == ST_CHECK);
    assign from_otp = sec[TBL_SEC_SECURE_BOOT]; // [R04] [R17]

    // OTP delivers one byte per cycle from a row, flash on each valid byte
    assign byte_ok  = in_image && (from_otp ? !otp_wait : flash_valid);
    assign byte_in  = from_otp ? otp_rdata[8*bcnt +: 8] : flash_data;
    assign word_in  = {byte_in, shreg[31:8]}; // [R07]
    assign crc_init = (state == ST_SECLD);
    assign crc_step = byte_ok && (state != ST_CHECK); // [R09]

    tbl_crc32 u_crc (
        .pclk    (pclk),
        .presetn (presetn),
        .init    (crc_init),
        .step    (crc_step),
        .din     (byte_in),
        .crc     (crc)
    );

    tbl_otp #(
        .SECTORS (TBL_OTP_SECTORS),
        .ROWS    (TBL_OTP_ROWS)
    ) u_otp (
        .pclk     (pclk),
        .presetn  (presetn),
        .raddr    (otp_row),
        .rdata    (otp_rdata),
        .wr       (prog_wr),
        .waddr    (prog_addr),
        .wdata    (prog_data),
        .lock     (sec[TBL_SEC_LOCK_LO +: 4]), // [R19]
        .mlock    (sec[TBL_SEC_MASTER_LOCK]),  // [R20]
        .rejected (prog_rej)
    );

    // ****************************************
    // Boot sequencer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_DELAY;
            dly       <= 16'h0000;
            bcnt      <= 2'h0;
            shreg     <= 32'h0000_0000;
            words     <= 32'h0000_0000;
            wcnt      <= 32'h0000_0000;
            otp_row   <= 16'h0000;
            otp_wait  <= 1'b1;
            crc_err   <= 1'b0;
            bypass    <= 1'b0;
            ram_we    <= 1'b0;
            ram_addr  <= 16'h0000;
            ram_wdata <= 32'h0000_0000;
        end else begin
            ram_we <= 1'b0;
            case (state)
                ST_DELAY: begin
                    dly <= dly + 16'h0001;
                    if (dly == 16'(BOOT_DLY - 1)) begin // [R03]
                        state   <= ST_SECRD;
                        otp_row <= 16'h0000;
                    end
                end
                ST_SECRD: begin
                    state <= ST_SECLD;
                end
                ST_SECLD: begin
                    state    <= ST_LEN;
                    otp_row  <= 16'h0001; // [R12]
                    otp_wait <= 1'b1;
                end
                ST_LEN, ST_PROG, ST_CHECK: begin
                    if (from_otp && otp_wait) begin
                        otp_wait <= 1'b0;
                    end
                    if (byte_ok) begin
                        shreg <= word_in;
                        bcnt  <= bcnt + 2'h1;
                        if (bcnt == 2'h3) begin
                            otp_row  <= otp_row + 16'h0001;
                            otp_wait <= 1'b1;
                            if (state == ST_LEN) begin
                                words <= word_in; // [R05]
                                wcnt  <= 32'h0000_0000;
                                state <= (word_in == 32'h0000_0000) ? ST_CHECK : ST_PROG;
                            end else if (state == ST_PROG) begin
                                ram_we    <= 1'b1;
                                ram_addr  <= wcnt[15:0]; // [R08]
                                ram_wdata <= word_in;
                                wcnt      <= wcnt + 32'h0000_0001;
                                if (wcnt + 32'h0000_0001 == words) begin
                                    state <= ST_CHECK;
                                end
                            end else begin
                                bypass  <= (word_in == TBL_CRC_BYPASS); // [R06]
                                crc_err <= (word_in != TBL_CRC_BYPASS) && (word_in != ~crc); // [R10]
                                state   <= ST_VERIFY;
                            end
                        end
                    end
                end
                ST_VERIFY: begin
                    state <= crc_err ? ST_FAIL : ST_RUN; // [R23]
                end
                ST_RUN, ST_FAIL: begin
                    state <= state;
                end
                default: begin
                    state <= ST_DELAY;
                end
            endcase
        end
    end

    // ****************************************
    // Security register and its gates
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec <= TBL_RESET_SEC;
        end else if (state == ST_SECLD) begin
            sec <= otp_rdata; // [R11]
        end else if (apb_wr && paddr == TBL_OFF_SEC) begin
            // Only the user field is software writable; locks come from fuses
            sec <= (sec & ~TBL_SEC_USER_MASK) | (pwdata & TBL_SEC_USER_MASK); // [R22]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_pulldown <= 1'b1; // [R01]
            core_run      <= 1'b0;
            core_pc       <= 32'h0000_0000;
            debug_en      <= 1'b0;
            link_en       <= 1'b0;
            dbg_otp_en    <= 1'b0;
            otp_redundant <= 1'b0;
            flash_req     <= 1'b0;
            flash_ready   <= 1'b0;
        end else begin
            gpio_pulldown <= (state == ST_DELAY);               // [R01]
            core_run      <= (state == ST_RUN);                 // [R23]
            core_pc       <= 32'h0000_0000;                     // [R08]
            debug_en      <= !sec[TBL_SEC_NO_DEBUG];            // [R15]
            link_en       <= !sec[TBL_SEC_NO_LINK];             // [R16]
            dbg_otp_en    <= !sec[TBL_SEC_NO_DBG_OTP];          // [R21]
            otp_redundant <= sec[TBL_SEC_REDUNDANT];            // [R18]
            flash_req     <= in_image && !from_otp;             // [R04]
            flash_ready   <= 1'b0;
        end
    end

    // ****************************************
    // APB slave, zero wait states
    // ****************************************
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;

    // Programming strobe: address and data staged, then control fires
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_addr <= 16'h0000;
            prog_data <= 32'h0000_0000;
            prog_wr   <= 1'b0;
        end else begin
            prog_wr <= 1'b0;
            if (apb_wr && paddr == TBL_OFF_OTP_ADDR) begin
                prog_addr <= pwdata[15:0]; // [R14]
            end else if (apb_wr && paddr == TBL_OFF_OTP_DATA) begin
                prog_data <= pwdata; // [R14]
            end else if (apb_wr && paddr == TBL_OFF_CTRL && pwdata[TBL_CTRL_PROG_GO]) begin
                prog_wr <= 1'b1; // [R14]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                if (paddr == TBL_OFF_SEC) begin
                    prdata <= sec;
                end else if (paddr == TBL_OFF_STAT) begin
                    prdata <= {27'h0, bypass, prog_rej, crc_err, core_run, state == ST_RUN || state == ST_FAIL};
                end else if (paddr == TBL_OFF_OTP_ADDR) begin
                    prdata <= {16'h0000, prog_addr};
                end else if (paddr == TBL_OFF_OTP_DATA) begin
                    prdata <= prog_data;
                end else if (paddr == TBL_OFF_CRC) begin
                    prdata <= ~crc;
                end else if (paddr == TBL_OFF_LEN) begin
                    prdata <= words;
                end else if (paddr == TBL_OFF_CTRL) begin
                    prdata <= 32'h0000_0000;
                end else begin
                    prdata  <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_check_done;
        state == ST_VERIFY;
    endsequence

    a_fail_no_run: assert property (@(posedge pclk) disable iff (!presetn) // [R23]
        s_check_done ##0 crc_err |=> state == ST_FAIL ##1 !core_run)
        else $error("core started after crc error");
    a_bypass_ok: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
        s_check_done ##0 bypass |-> !crc_err)
        else $error("bypass word still failed crc");
    a_pull_down: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
        state != ST_DELAY |=> !gpio_pulldown)
        else $error("pull-downs left on after boot start");
    a_ram_base: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
        $rose(ram_we) && $past(state) == ST_PROG && wcnt == 32'h1 |-> ram_addr == 16'h0000)
        else $error("first word not at ram base");
    a_debug_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        sec[TBL_SEC_NO_DEBUG] |=> !debug_en)
        else $error("debug allowed while disabled");
    a_link_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
        sec[TBL_SEC_NO_LINK] |=> !link_en)
        else $error("switch access allowed while disabled");
    a_master_lock: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
        prog_wr && sec[TBL_SEC_MASTER_LOCK] |=> prog_rej)
        else $error("programming passed master lock");
    a_sec_load: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        state == ST_SECLD |=> sec == $past(otp_rdata))
        else $error("security word not loaded from otp");
    a_boot_delay: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
        state == ST_SECRD |-> dly == 16'(BOOT_DLY))
        else $error("boot started at wrong delay");
endmodule : tbl_boot

// ---- rtl/tbl_crc32.sv ----
// Purpose: Byte-serial reflected CRC-32 engine.
// Assumes: One byte per cycle when step is high.
// Notes:   Remainder is exposed raw; caller inverts it.
`timescale 1ns/1ps
module tbl_crc32 (
    input  wire logic        pclk,    // Clock
    input  wire logic        presetn, // Async reset, low
    input  wire logic        init,    // Load seed
    input  wire logic        step,    // Absorb byte
    input  wire logic [7:0]  din,     // Byte in
    output logic      [31:0] crc      // Running remainder
);
    import tbl_pkg::*;

    logic [31:0] next_crc;

    always_comb begin
        next_crc = crc ^ {24'h000000, din};
        for (int i = 0; i < 8; i++) begin
            next_crc = next_crc[0] ? ((next_crc >> 1) ^ TBL_CRC_POLY) : (next_crc >> 1); // [R10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc <= TBL_CRC_SEED;
        end else if (init) begin
            crc <= TBL_CRC_SEED; // [R10]
        end else if (step) begin
            crc <= next_crc;
        end
    end
endmodule : tbl_crc32

// ---- rtl/tbl_otp.sv ----
// Purpose: OTP array of four sectors with guarded programming.
// Assumes: Row address combines sector and row index.
// Notes:   Programming only sets bits, as fuses do.
`timescale 1ns/1ps
module tbl_otp #(
    parameter int SECTORS = 4,
    parameter int ROWS    = 512
) (
    input  wire logic        pclk,     // Clock
    input  wire logic        presetn,  // Async reset, low
    input  wire logic [15:0] raddr,    // Read row
    output logic      [31:0] rdata,    // Read data, one cycle later
    input  wire logic        wr,       // Program strobe
    input  wire logic [15:0] waddr,    // Program row
    input  wire logic [31:0] wdata,    // Bits to blow
    input  wire logic [3:0]  lock,     // Sector locks
    input  wire logic        mlock,    // Master lock
    output logic             rejected  // Last program refused
);
    logic [31:0] mem [SECTORS*ROWS]; // [R13]
    logic [1:0]  wsec;
    logic        ok;

    assign wsec = waddr[10:9];
    assign ok   = !mlock && !lock[wsec] && (waddr < 16'(SECTORS*ROWS)); // [R19] [R20]

    always_ff @(posedge pclk) begin
        if (wr && ok) begin
            mem[waddr[10:0]] <= mem[waddr[10:0]] | wdata;
        end
        rdata <= mem[raddr[10:0]];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rejected <= 1'b0;
        end else if (wr) begin
            rejected <= !ok;
        end
    end
endmodule : tbl_otp

// ---- rtl/tbl_pkg.sv ----
// Purpose: Constants for the tile boot loader and security block.
// Assumes: 25 MHz pclk, APB register access.
// Notes:   Function list below; offsets of the APB map are local choices.
// Function
// [R01] Hold tile in reset, pull-downs while low
// [R02] Controller holds reset until supply settles
// [R03] Boot starts 15 to 150 us after release
// [R04] Security bit five selects OTP boot source
// [R05] Parse length word, program words, check word
// [R06] Bypass constant skips CRC verification
// [R07] Length and check words little-endian
// [R08] Program at lowest RAM address, start there
// [R09] CRC covers length word and program bytes
// [R10] Reflected polynomial, all-ones seed, final inversion
// [R11] Security register loaded from OTP at power-up
// [R12] Further OTP data copied to SRAM first
// [R13] OTP has four sectors of 512 rows
// [R14] OTP programmed via address, data, control ports
// [R15] Bit zero disables debug test port
// [R16] Bit one refuses switch access to processor
// [R17] Secure boot starts from OTP address zero; code reads image from row 1, row 0 holds security word
// [R18] Bit seven enables OTP redundant rows
// [R19] Bits eight to eleven lock sectors
// [R20] Master lock rejects all programming updates
// [R21] Bit thirteen blocks debug access to OTP
// [R22] Bits 21:15 user field, 31:22 user id
// [R23] CRC mismatch prevents program start
package tbl_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  TBL_OFF_SEC      = 8'h00;
    localparam logic [7:0]  TBL_OFF_CTRL     = 8'h04;
    localparam logic [7:0]  TBL_OFF_STAT     = 8'h08;
    localparam logic [7:0]  TBL_OFF_OTP_ADDR = 8'h0c;
    localparam logic [7:0]  TBL_OFF_OTP_DATA = 8'h10;
    localparam logic [7:0]  TBL_OFF_CRC      = 8'h14;
    localparam logic [7:0]  TBL_OFF_LEN      = 8'h18;
    // ****************************************
    // Security register fields
    // ****************************************
    localparam int TBL_SEC_NO_DEBUG    = 0;
    localparam int TBL_SEC_NO_LINK     = 1;
    localparam int TBL_SEC_SECURE_BOOT = 5;
    localparam int TBL_SEC_REDUNDANT   = 7;
    localparam int TBL_SEC_LOCK_LO     = 8;
    localparam int TBL_SEC_MASTER_LOCK = 12;
    localparam int TBL_SEC_NO_DBG_OTP  = 13;
    localparam int TBL_SEC_USER_LO     = 15;
    localparam int TBL_SEC_USER_HI     = 21;
    localparam logic [31:0] TBL_SEC_USER_MASK = 32'h003f_8000;
    // ****************************************
    // Control and status bits
    // ****************************************
    localparam int TBL_CTRL_PROG_GO  = 0;
    localparam int TBL_CTRL_SEC_WR   = 1;
    localparam int TBL_STAT_DONE     = 0;
    localparam int TBL_STAT_RUN      = 1;
    localparam int TBL_STAT_CRC_ERR  = 2;
    localparam int TBL_STAT_PROG_REJ = 3;
    localparam int TBL_STAT_BYPASS   = 4;
    // ****************************************
    // Image and CRC
    // ****************************************
    localparam logic [31:0] TBL_CRC_BYPASS = 32'h0d15_ab1e;
    localparam logic [31:0] TBL_CRC_POLY   = 32'hedb8_8320;
    localparam logic [31:0] TBL_CRC_SEED   = 32'hffff_ffff;
    localparam logic [31:0] TBL_RESET_SEC  = 32'h0000_0000;
    // ****************************************
    // OTP geometry
    // ****************************************
    localparam int TBL_OTP_SECTORS = 4;
    localparam int TBL_OTP_ROWS    = 512;
    localparam logic [15:0] TBL_OTP_SEC_ROW = 16'h07ff;
    // ****************************************
    // Timing
    // ****************************************
    localparam int TBL_CLK_MHZ       = 25;
    localparam int TBL_BOOT_DLY_US   = 15;
    localparam int TBL_BOOT_DLY_CYC  = TBL_BOOT_DLY_US * TBL_CLK_MHZ;
endpackage : tbl_pkg

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the tile boot loader.
// Assumes: Short boot delay; APB zero wait states allowed, not assumed.
// Notes:   RAM writes are checked against a queue of expected words.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    import tbl_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, flash_data;
    logic [31:0] pwdata, prdata, ram_wdata, core_pc;
    logic        flash_valid, flash_ready, flash_req, ram_we, core_run;
    logic [15:0] ram_addr;
    logic        gpio_pulldown, debug_en, link_en, dbg_otp_en, otp_redundant;
    logic [47:0] exp_q[$];
    int          bad_count, n_tests, cyc;
    tbl_boot #(.BOOT_DLY(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_valid(flash_valid), .flash_data(flash_data),
        .flash_ready(flash_ready), .flash_req(flash_req), .ram_we(ram_we), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .core_run(core_run), .core_pc(core_pc),
        .gpio_pulldown(gpio_pulldown), .debug_en(debug_en), .link_en(link_en),
        .dbg_otp_en(dbg_otp_en), .otp_redundant(otp_redundant));
    tbl_flash_model u_flash (.pclk(pclk), .flash_req(flash_req), .flash_valid(flash_valid),
        .flash_data(flash_data));
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        // Unblown fuses read as zero, so the first boots come from flash
        for (int i = 0; i < TBL_OTP_SECTORS * TBL_OTP_ROWS; i++) dut.u_otp.mem[i] = 32'h0;
    end
    always #20 pclk = ~pclk;
    // ****************************************
    // Scoreboard and timeout
    // ****************************************
    always @(posedge pclk) begin
        if (presetn && ram_we === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(ram_we, 1'b0)
            end else begin
                `CHK({ram_addr, ram_wdata}, exp_q.pop_front())
            end
        end
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] crc_of(input logic [7:0] b[$]);
        logic [31:0] c;
        c = TBL_CRC_SEED;
        foreach (b[i]) begin
            c ^= {24'h0, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ TBL_CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction : crc_of
    // Mode 0 good check word, 1 bypass value, 2 corrupted check word
    task automatic run_boot(input int mode);
        logic [7:0]  img[$];
        logic [31:0] w, s, c, st, rd;
        logic        e;
        int          k;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        `CHK(gpio_pulldown, 1'b1)
        `CHK(core_run, 1'b0)
        s = 2 + $urandom % 3;
        u_flash.q.delete();
        exp_q.delete();
        for (k = 0; k < 4; k++) img.push_back(s[8*k+:8]);
        for (int i = 0; i < s; i++) begin
            w = $urandom;
            exp_q.push_back({i[15:0], w});
            for (k = 0; k < 4; k++) img.push_back(w[8*k+:8]);
        end
        c = (mode == 1) ? TBL_CRC_BYPASS : crc_of(img) ^ ((mode == 2) ? 32'h1 : 32'h0);
        for (k = 0; k < 4; k++) img.push_back(c[8*k+:8]);
        // Mode 3 boots from fuses: security bits 0,1,5,7,12,13 set, image from row 1
        if (mode == 3) begin
            dut.u_otp.mem[0] = 32'h0000_30a3;
            for (k = 0; k < img.size() / 4; k++)
                dut.u_otp.mem[k + 1] = {img[4*k+3], img[4*k+2], img[4*k+1], img[4*k]};
        end else begin
            foreach (img[i]) u_flash.q.push_back(img[i]);
        end
        @(posedge pclk);
        presetn <= 1'b1;
        k = 0;
        do begin
            apb(1'b0, TBL_OFF_STAT, 32'h0, st, e);
            k++;
        end while (st[TBL_STAT_DONE] !== 1'b1 && k < 300);
        `CHK(core_run, mode != 2)
        `CHK(core_pc, 32'h0)
        `CHK(gpio_pulldown, 1'b0)
        `CHK(st[TBL_STAT_CRC_ERR], mode == 2)
        `CHK(st[TBL_STAT_BYPASS], mode == 1)
        `CHK(debug_en, mode != 3)
        `CHK(link_en, mode != 3)
        `CHK(dbg_otp_en, mode != 3)
        `CHK(otp_redundant, mode == 3)
        `CHK(flash_ready, 1'b0)
        apb(1'b0, TBL_OFF_LEN, 32'h0, rd, e);
        `CHK(rd, s)
        `CHK(exp_q.size(), 0)
    endtask : run_boot
    initial begin
        logic [31:0] v0, rd;
        logic        e;
        void'($urandom(72766));
        run_boot(0);
        u_flash.slow = 1'b1;
        run_boot(1);
        run_boot(2);
        run_boot(3);
        apb(1'b1, TBL_OFF_OTP_ADDR, 32'h0000_0201, rd, e);
        apb(1'b1, TBL_OFF_OTP_DATA, $urandom, rd, e);
        apb(1'b1, TBL_OFF_CTRL, 32'h0000_0001, rd, e);
        apb(1'b0, TBL_OFF_STAT, 32'h0, rd, e);
        `CHK(rd[TBL_STAT_PROG_REJ], 1'b1)
        apb(1'b0, TBL_OFF_OTP_ADDR, 32'h0, rd, e);
        `CHK(rd, 32'h0000_0201)
        apb(1'b0, TBL_OFF_SEC, 32'h0, v0, e);
        apb(1'b1, TBL_OFF_SEC, 32'hffff_ffff, rd, e);
        apb(1'b0, TBL_OFF_SEC, 32'h0, rd, e);
        `CHK(rd, v0 | TBL_SEC_USER_MASK)
        apb(1'b0, 8'h40, 32'h0, rd, e);
        `CHK(e, 1'b1)
        tally_and_finish();
    end
endmodule : tb_top

// ---- sim/tbl_flash_model.sv ----
// Purpose: Behavioural flash byte source for the boot loader.
// Assumes: A byte is taken at every edge where flash_valid is high.
// Notes:   The slow setting inserts random stall cycles.
`timescale 1ns/1ps
module tbl_flash_model (
    input  wire logic       pclk,        // Clock
    input  wire logic       flash_req,   // Loader reading
    output logic            flash_valid, // Byte offered
    output logic      [7:0] flash_data   // Byte value
);
    logic [7:0] q[$];
    bit         slow;
    initial begin
        flash_valid = 1'b0;
        flash_data  = 8'h00;
        slow        = 1'b0;
    end
    // Idle data toggles so a stale byte can never look valid by luck
    always @(posedge pclk) begin
        if (flash_valid && q.size() > 0)
            void'(q.pop_front());
        if (flash_req && q.size() > 0 && !(slow && $urandom % 2)) begin
            flash_valid <= 1'b1;
            flash_data  <= q[0];
        end else begin
            flash_valid <= 1'b0;
            flash_data  <= ~flash_data;
        end
    end
endmodule : tbl_flash_model
